/* File: bcc_regs.svh */
// Register offset, field positions, reset values and timing counts
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH

`define BCC_CTRL0_OFFSET    8'h40
`define BCC_FC_RATE_BIT     15
`define BCC_RETRY_STS_BIT   16
`define BCC_RETRY_LIM_LO    17
`define BCC_RETRY_LIM_HI    18
`define BCC_DISC_DIS_BIT    19
`define BCC_DISC_SHORT_BIT  20
`define BCC_CFG_TMO_LO      21
`define BCC_CFG_TMO_HI      22
`define BCC_DT_ORDER_BIT    23
`define BCC_CPL_TMO_LO      24
`define BCC_CPL_TMO_HI      25
`define BCC_ISO_EN_BIT      26
`define BCC_ISO_TC_LO       27
`define BCC_ISO_TC_HI       29
`define BCC_LOOP_BIT        30
`define BCC_LOCK_BIT        31

`define BCC_RETRY_LIM_RST   2'h0
`define BCC_CFG_TMO_RST     2'h1
`define BCC_CPL_TMO_RST     2'h1
`define BCC_ISO_TC_RST      3'h1

`define BCC_RETRY_256       32'h0000_0100
`define BCC_RETRY_64K       32'h0001_0000
`define BCC_RETRY_2G        32'h8000_0000
`define BCC_DISC_SHORT_CLKS 16'h0040
`define BCC_DISC_LONG0      16'h8000
`define BCC_DISC_LONG1      16'h0400

// Times in ns, cycles at 40 MHz (25 ns period)
`define BCC_CLK_NS          25
`define BCC_CFG_T0_NS       25000
`define BCC_CFG_T1_NS       500000
`define BCC_CFG_T2_NS       5000000
`define BCC_CFG_T3_NS       25000000
`define BCC_CPL_T0_NS       50000
`define BCC_CPL_T1_NS       1000000
`define BCC_CPL_T2_NS       10000000
`define BCC_CPL_T3_NS       50000000
`define BCC_CYC(ns)         ((ns) / `BCC_CLK_NS)

`endif

/* File: bcc_pkg.sv */
// Types shared by the chip control block
package bcc_pkg;
    typedef logic [31:0] bcc_word_type;
    typedef logic [2:0]  bcc_tc_type;
    typedef enum logic { BCC_FORWARD, BCC_REVERSE } bcc_dir_type;
    typedef enum logic [1:0] { BCC_CFG_OK, BCC_CFG_CRS,
                               BCC_CFG_RETRY } bcc_cfg_ans_type;
endpackage : bcc_pkg

/* File: bcc_timer.sv */
// Down counter timer with selectable load value
`timescale 1ns/1ps
`include "bcc_regs.svh"
module bcc_timer (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Control
    input  wire logic        start,
    input  wire logic        stop,
    input  wire logic [31:0] load_value,
    // Status
    output logic             expired
);
    import bcc_pkg::*;

    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic        run_reg;
    logic        run_next;
    logic        expired_next;

    always_comb begin
        count_next   = count_reg;
        run_next     = run_reg;
        expired_next = 1'b0;
        if (start) begin
            count_next = load_value;
            run_next   = 1'b1;
        end else if (stop) begin
            run_next = 1'b0;
        end else if (run_reg) begin
            if (count_reg <= 32'h0000_0001) begin
                expired_next = 1'b1;
                run_next     = 1'b0;
            end
            count_next = count_reg - 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            count_reg <= 32'h0000_0000;
            run_reg   <= 1'b0;
            expired   <= 1'b0;
        end else begin
            count_reg <= count_next;
            run_reg   <= run_next;
            expired   <= expired_next;
        end
    end
endmodule : bcc_timer

/* File: bcc_chip_ctrl.sv */
// Bits 31 to 15 of chip control register 0 and the logic they steer
`timescale 1ns/1ps
`include "bcc_regs.svh"
module bcc_chip_ctrl (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     reset,
    // Straps
    input  wire logic                     test_strap_a,
    input  wire logic                     test_strap_b,
    input  wire logic                     test_strap_c,
    input  wire logic                     mask_input_strap,
    input  wire logic                     reverse_mode_strap,
    // Configuration access
    input  wire logic                     cfg_wr,
    input  wire logic                     cfg_rd,
    input  wire logic [7:0]               cfg_addr,
    input  wire logic [3:0]               cfg_be,
    input  wire bcc_pkg::bcc_word_type    cfg_wdata,
    input  wire logic                     cfg_from_primary,
    output bcc_pkg::bcc_word_type         cfg_rdata,
    output bcc_pkg::bcc_cfg_ans_type      cfg_answer,
    // Bridge control register bits
    input  wire logic                     brc_disc_dis,
    input  wire logic                     brc_disc_fwd,
    input  wire logic                     brc_disc_rev,
    // Core events
    input  wire logic                     pci_retry,
    input  wire logic                     pci_retry_done,
    input  wire logic                     cfg_retry_start,
    input  wire logic                     cpl_start,
    input  wire logic                     cpl_done,
    input  wire logic                     mem_to_serial,
    // Steered outputs
    output logic                          fc_update_each,
    output logic                          discard_en,
    output logic [15:0]                   discard_clks,
    output logic                          dt_in_order,
    output bcc_pkg::bcc_tc_type           tc_out,
    output logic                          serial_loopback,
    output logic                          cfg_retry_expired,
    output logic                          cpl_timeout,
    output bcc_pkg::bcc_dir_type          bridge_dir
);
    import bcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic        fc_reg, fc_next;
    logic        sts_reg, sts_next;
    logic [1:0]  lim_reg, lim_next;
    logic        ddis_reg, ddis_next;
    logic        dshort_reg, dshort_next;
    logic [1:0]  cfgt_reg, cfgt_next;
    logic        dto_reg, dto_next;
    logic [1:0]  cplt_reg, cplt_next;
    logic        iso_reg, iso_next;
    logic [2:0]  tc_reg, tc_next;
    logic        loop_reg, loop_next;
    logic        lock_reg, lock_next;
    logic        init_reg;
    logic [31:0] rcnt_reg, rcnt_next;
    bcc_dir_type dir_reg, dir_next;
    logic        hit_wr;
    logic        refuse;
    logic        loop_ok;
    logic [31:0] lim_val;
    logic [31:0] cfg_load;
    logic [31:0] cpl_load;
    logic        retry_exp;
    bcc_word_type    rdata_next;
    bcc_cfg_ans_type ans_next;

    // Locked-out primary accesses change nothing and read back zero
    assign refuse  = cfg_from_primary && lock_reg;
    assign hit_wr  = cfg_wr && (cfg_addr == `BCC_CTRL0_OFFSET) && !refuse;
    assign loop_ok = !test_strap_a && test_strap_b && test_strap_c
                     && mask_input_strap && reverse_mode_strap;

    always_comb begin
        case (lim_reg)
            2'h1:    lim_val = `BCC_RETRY_256;
            2'h2:    lim_val = `BCC_RETRY_64K;
            2'h3:    lim_val = `BCC_RETRY_2G;
            default: lim_val = 32'h0000_0000;
        endcase
        case (cfgt_reg)
            2'h0:    cfg_load = `BCC_CYC(`BCC_CFG_T0_NS);
            2'h1:    cfg_load = `BCC_CYC(`BCC_CFG_T1_NS);
            2'h2:    cfg_load = `BCC_CYC(`BCC_CFG_T2_NS);
            default: cfg_load = `BCC_CYC(`BCC_CFG_T3_NS);
        endcase
        case (cplt_reg)
            2'h0:    cpl_load = `BCC_CYC(`BCC_CPL_T0_NS);
            2'h1:    cpl_load = `BCC_CYC(`BCC_CPL_T1_NS);
            2'h2:    cpl_load = `BCC_CYC(`BCC_CPL_T2_NS);
            default: cpl_load = `BCC_CYC(`BCC_CPL_T3_NS);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next register values
    always_comb begin
        fc_next     = fc_reg;
        sts_next    = sts_reg;
        lim_next    = lim_reg;
        ddis_next   = ddis_reg;
        dshort_next = dshort_reg;
        cfgt_next   = cfgt_reg;
        dto_next    = dto_reg;
        cplt_next   = cplt_reg;
        iso_next    = iso_reg;
        tc_next     = tc_reg;
        loop_next   = loop_reg;
        lock_next   = lock_reg;
        dir_next    = dir_reg;
        rcnt_next   = rcnt_reg;
        if (init_reg) begin
            dir_next  = reverse_mode_strap ? BCC_REVERSE : BCC_FORWARD;
            lock_next = test_strap_a;
        end
        if (hit_wr && cfg_be[1])
            fc_next = cfg_wdata[`BCC_FC_RATE_BIT];
        if (hit_wr && cfg_be[2]) begin
            if (cfg_wdata[`BCC_RETRY_STS_BIT])
                sts_next = 1'b0;
            lim_next    = cfg_wdata[`BCC_RETRY_LIM_HI:`BCC_RETRY_LIM_LO];
            ddis_next   = cfg_wdata[`BCC_DISC_DIS_BIT];
            dshort_next = cfg_wdata[`BCC_DISC_SHORT_BIT];
            cfgt_next   = cfg_wdata[`BCC_CFG_TMO_HI:`BCC_CFG_TMO_LO];
            dto_next    = cfg_wdata[`BCC_DT_ORDER_BIT];
        end
        if (hit_wr && cfg_be[3]) begin
            cplt_next = cfg_wdata[`BCC_CPL_TMO_HI:`BCC_CPL_TMO_LO];
            iso_next  = cfg_wdata[`BCC_ISO_EN_BIT];
            tc_next   = cfg_wdata[`BCC_ISO_TC_HI:`BCC_ISO_TC_LO];
            if (dir_reg == BCC_REVERSE)
                loop_next = cfg_wdata[`BCC_LOOP_BIT];
            if (dir_reg == BCC_REVERSE || !cfg_from_primary)
                lock_next = cfg_wdata[`BCC_LOCK_BIT];
        end
        if (hit_wr && cfg_be[2])
            lim_next = cfg_wdata[`BCC_RETRY_LIM_HI:`BCC_RETRY_LIM_LO];
        // Retry counter: counts retries up to the limit and holds there
        if (pci_retry_done || lim_reg == 2'h0)
            rcnt_next = 32'h0000_0000;
        else if (pci_retry && rcnt_reg != lim_val)
            rcnt_next = rcnt_reg + 32'h0000_0001;
        retry_exp = (lim_reg != 2'h0) && pci_retry && !pci_retry_done
                    && (rcnt_reg + 32'h0000_0001 == lim_val);
        if (retry_exp)
            sts_next = 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            fc_reg     <= 1'b0;
            sts_reg    <= 1'b0;
            lim_reg    <= `BCC_RETRY_LIM_RST;
            ddis_reg   <= 1'b0;
            dshort_reg <= 1'b0;
            cfgt_reg   <= `BCC_CFG_TMO_RST;
            dto_reg    <= 1'b0;
            cplt_reg   <= `BCC_CPL_TMO_RST;
            iso_reg    <= 1'b0;
            tc_reg     <= `BCC_ISO_TC_RST;
            loop_reg   <= 1'b0;
            lock_reg   <= 1'b0;
            init_reg   <= 1'b1;
            rcnt_reg   <= 32'h0000_0000;
            dir_reg    <= BCC_FORWARD;
        end else begin
            fc_reg     <= fc_next;
            sts_reg    <= sts_next;
            lim_reg    <= lim_next;
            ddis_reg   <= ddis_next;
            dshort_reg <= dshort_next;
            cfgt_reg   <= cfgt_next;
            dto_reg    <= dto_next;
            cplt_reg   <= cplt_next;
            iso_reg    <= iso_next;
            tc_reg     <= tc_next;
            loop_reg   <= loop_next;
            lock_reg   <= lock_next;
            init_reg   <= 1'b0;
            rcnt_reg   <= rcnt_next;
            dir_reg    <= dir_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timeout timers
    bcc_timer u_cfg_timer (
        .mclk       (mclk),
        .reset      (reset),
        .start      (cfg_retry_start),
        .stop       (1'b0),
        .load_value (cfg_load),
        .expired    (cfg_retry_expired)
    );

    bcc_timer u_cpl_timer (
        .mclk       (mclk),
        .reset      (reset),
        .start      (cpl_start),
        .stop       (cpl_done),
        .load_value (cpl_load),
        .expired    (cpl_timeout)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data, access answer and steered outputs
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (cfg_rd && cfg_addr == `BCC_CTRL0_OFFSET && !refuse)
            rdata_next = {lock_reg, loop_reg, tc_reg, iso_reg, cplt_reg,
                          dto_reg, cfgt_reg, dshort_reg, ddis_reg,
                          lim_reg, sts_reg, fc_reg, 15'h0000};
        ans_next = BCC_CFG_OK;
        if ((cfg_rd || cfg_wr) && refuse)
            ans_next = (dir_reg == BCC_FORWARD) ? BCC_CFG_CRS : BCC_CFG_RETRY;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_rdata       <= 32'h0000_0000;
            cfg_answer      <= BCC_CFG_OK;
            fc_update_each  <= 1'b0;
            discard_en      <= 1'b0;
            discard_clks    <= `BCC_DISC_SHORT_CLKS;
            dt_in_order     <= 1'b0;
            tc_out          <= 3'h0;
            serial_loopback <= 1'b0;
            bridge_dir      <= BCC_FORWARD;
        end else begin
            cfg_rdata       <= rdata_next;
            cfg_answer      <= ans_next;
            fc_update_each  <= fc_reg;
            discard_en      <= !ddis_reg && !brc_disc_dis;
            if (dshort_reg)
                discard_clks <= `BCC_DISC_SHORT_CLKS;
            else if ((dir_reg == BCC_FORWARD ? brc_disc_fwd : brc_disc_rev))
                discard_clks <= `BCC_DISC_LONG1;
            else
                discard_clks <= `BCC_DISC_LONG0;
            dt_in_order     <= dto_reg;
            tc_out          <= (iso_reg && mem_to_serial) ? tc_reg
                                                          : 3'h0;
            serial_loopback <= loop_reg && loop_ok;
            bridge_dir      <= dir_reg;
        end
    end
endmodule : bcc_chip_ctrl

/* File: bcc_chip_ctrl_props.sv */
// Concurrent checks on the chip control block ports
`timescale 1ns/1ps
module bcc_chip_ctrl_props (
    // Clock and reset
    input wire logic                  mclk,
    input wire logic                  reset,
    // Straps
    input wire logic                  test_strap_a,
    input wire logic                  test_strap_b,
    input wire logic                  test_strap_c,
    input wire logic                  mask_input_strap,
    input wire logic                  reverse_mode_strap,
    // Access and bridge control
    input wire logic                  cfg_wr,
    input wire logic                  cfg_rd,
    input wire logic [7:0]            cfg_addr,
    input wire logic                  cfg_from_primary,
    input wire bcc_pkg::bcc_cfg_ans_type cfg_answer,
    input wire logic                  brc_disc_fwd,
    input wire logic                  brc_disc_rev,
    // Outputs
    input wire logic [15:0]           discard_clks,
    input wire logic                  serial_loopback,
    input wire bcc_pkg::bcc_dir_type  bridge_dir
);
    import bcc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic acc;
    logic sel;
    assign acc = (cfg_wr || cfg_rd) && cfg_addr == 8'h40;
    assign sel = (bridge_dir == BCC_REVERSE) ? brc_disc_rev : brc_disc_fwd;
    sequence s_sec;
        acc && !cfg_from_primary;
    endsequence
    sequence s_ok_next;
        ##1 cfg_answer == BCC_CFG_OK;
    endsequence
    property p_crs;
        cfg_answer == BCC_CFG_CRS |->
            bridge_dir == BCC_FORWARD && $past(cfg_from_primary);
    endproperty
    property p_retry;
        cfg_answer == BCC_CFG_RETRY |->
            bridge_dir == BCC_REVERSE && $past(cfg_from_primary);
    endproperty
    property p_sec_ok;
        s_sec |-> s_ok_next;
    endproperty
    property p_idle_ok;
        !(cfg_wr || cfg_rd) |-> s_ok_next;
    endproperty
    property p_loop;
        serial_loopback |-> !test_strap_a && test_strap_b && test_strap_c
            && mask_input_strap && reverse_mode_strap;
    endproperty
    property p_loop_fwd;
        bridge_dir == BCC_FORWARD |-> !serial_loopback;
    endproperty
    property p_dir;
        !$past(reset) && !$past(reset, 2) && !$past(reset, 3)
            |-> $stable(bridge_dir);
    endproperty
    property p_disc;
        !$past(reset) && $stable(sel) && discard_clks != 16'h0040 |->
            discard_clks == ($past(sel) ? 16'h0400 : 16'h8000);
    endproperty
    a_crs: assert property (p_crs) else $error("bad CRS answer");
    a_retry: assert property (p_retry) else $error("bad retry");
    a_sec_ok: assert property (p_sec_ok) else $error("sec refused");
    a_idle_ok: assert property (p_idle_ok) else $error("idle answer");
    a_loop: assert property (p_loop) else $error("loop straps");
    a_loop_fwd: assert property (p_loop_fwd) else $error("loop fwd");
    a_dir: assert property (p_dir) else $error("direction moved");
    a_disc: assert property (p_disc) else $error("discard count");
endmodule : bcc_chip_ctrl_props

/* File: bcc_cfg_host.sv */
// Configuration software model issuing single accesses
`timescale 1ns/1ps
module bcc_cfg_host (
    // Clock
    input wire logic                   mclk,
    // Requests
    output logic                       cfg_wr,
    output logic                       cfg_rd,
    output logic [7:0]                 cfg_addr,
    output logic [3:0]                 cfg_be,
    output bcc_pkg::bcc_word_type      cfg_wdata,
    output logic                       cfg_from_primary,
    // Answers
    input wire bcc_pkg::bcc_word_type  cfg_rdata,
    input wire bcc_pkg::bcc_cfg_ans_type cfg_answer
);
    import bcc_pkg::*;
    bcc_word_type    rd_data;
    bcc_cfg_ans_type rd_ans;
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h40;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
        cfg_from_primary = 1'b0;
    end
    task access(input logic wr, input logic prim, input logic [3:0] be,
                input bcc_word_type data);
        @(posedge mclk);
        cfg_wr <= wr;
        cfg_rd <= !wr;
        cfg_addr <= 8'h40;
        cfg_be <= be;
        cfg_wdata <= data;
        cfg_from_primary <= prim;
        @(posedge mclk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        // Released data must not keep its last value
        cfg_wdata <= ~data;
        #1;
        rd_data = cfg_rdata;
        rd_ans = cfg_answer;
    endtask : access
endmodule : bcc_cfg_host

/* File: bcc_chip_ctrl_tb_top.sv */
// Self-checking testbench for the chip control block
`timescale 1ns/1ps
module bcc_chip_ctrl_tb_top;
    import bcc_pkg::*;
    logic mclk, reset, test_strap_a, test_strap_b, test_strap_c;
    logic mask_input_strap, reverse_mode_strap;
    logic brc_disc_dis, brc_disc_fwd, brc_disc_rev, pci_retry;
    logic pci_retry_done, cfg_retry_start, cpl_start, cpl_done;
    logic mem_to_serial, cfg_wr, cfg_rd, cfg_from_primary;
    logic fc_update_each, discard_en, dt_in_order, serial_loopback;
    logic cfg_retry_expired, cpl_timeout;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [15:0] discard_clks;
    bcc_word_type cfg_wdata, cfg_rdata;
    bcc_cfg_ans_type cfg_answer;
    bcc_tc_type tc_out;
    bcc_dir_type bridge_dir;
    int error_cnt, samples_checked;
    bcc_chip_ctrl i_dut (.mclk(mclk), .reset(reset),
        .test_strap_a(test_strap_a), .test_strap_b(test_strap_b),
        .test_strap_c(test_strap_c), .mask_input_strap(mask_input_strap),
        .reverse_mode_strap(reverse_mode_strap), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_from_primary(cfg_from_primary),
        .cfg_rdata(cfg_rdata), .cfg_answer(cfg_answer),
        .brc_disc_dis(brc_disc_dis), .brc_disc_fwd(brc_disc_fwd),
        .brc_disc_rev(brc_disc_rev), .pci_retry(pci_retry),
        .pci_retry_done(pci_retry_done), .cfg_retry_start(cfg_retry_start),
        .cpl_start(cpl_start), .cpl_done(cpl_done),
        .mem_to_serial(mem_to_serial), .fc_update_each(fc_update_each),
        .discard_en(discard_en), .discard_clks(discard_clks),
        .dt_in_order(dt_in_order), .tc_out(tc_out),
        .serial_loopback(serial_loopback), .bridge_dir(bridge_dir),
        .cfg_retry_expired(cfg_retry_expired), .cpl_timeout(cpl_timeout));
    bcc_cfg_host i_host (.mclk(mclk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_from_primary(cfg_from_primary), .cfg_rdata(cfg_rdata),
        .cfg_answer(cfg_answer));
    ////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("Checks %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task chk(input bcc_word_type got, input bcc_word_type exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rdx(input logic prim, input bcc_word_type exp);
        i_host.access(1'b0, prim, 4'h0, 32'h0);
        chk(i_host.rd_data & 32'hFFFF_8000, exp);
    endtask : rdx
    task wr(input logic prim, input logic [3:0] be, input bcc_word_type d);
        i_host.access(1'b1, prim, be, d);
    endtask : wr
    task do_reset(input logic a, input logic rev);
        test_strap_a <= a;
        reverse_mode_strap <= rev;
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////
    task t_forward;
        do_reset(1'b1, 1'b0);
        rdx(1'b0, 32'h8920_0000);
        chk(bridge_dir, BCC_FORWARD);
        wr(1'b1, 4'hF, 32'h0);
        chk(i_host.rd_ans, BCC_CFG_CRS);
        rdx(1'b0, 32'h8920_0000);
        wr(1'b0, 4'hF, 32'hFFFF_FFFF);
        rdx(1'b0, 32'hBFFE_8000);
        chk({fc_update_each, discard_en, dt_in_order}, 3'h5);
        chk(discard_clks, 16'h0040);
        chk(tc_out, 3'h7);
        wr(1'b0, 4'h8, 32'h0);
        rdx(1'b0, 32'h00FE_8000);
        chk(tc_out, 3'h0);
        wr(1'b0, 4'hF, 32'h0);
        rdx(1'b1, 32'h0);
        chk(i_host.rd_ans, BCC_CFG_OK);
        chk({discard_en, discard_clks}, 17'h1_8000);
    endtask : t_forward
    task retries(input int cnt);
        @(posedge mclk) pci_retry <= 1'b1;
        repeat (cnt) @(posedge mclk);
        pci_retry <= 1'b0;
    endtask : retries
    task retry_end;
        @(posedge mclk) pci_retry_done <= 1'b1;
        @(posedge mclk) pci_retry_done <= 1'b0;
    endtask : retry_end
    task t_retry;
        wr(1'b0, 4'h4, 32'h0002_0000);
        retries(255);
        retry_end;
        retries(255);
        rdx(1'b0, 32'h0002_0000);
        retries(1);
        rdx(1'b0, 32'h0003_0000);
        wr(1'b0, 4'h4, 32'h0003_0000);
        rdx(1'b0, 32'h0002_0000);
        retry_end;
        retries(255);
        // Clear and expiry in one cycle: the expiry wins
        fork
            wr(1'b0, 4'h4, 32'h0003_0000);
            retries(1);
        join
        rdx(1'b0, 32'h0003_0000);
    endtask : t_retry
    task t_timer;
        int n;
        int t_cfg;
        int t_cpl;
        t_cfg = 0;
        t_cpl = 0;
        wr(1'b0, 4'hF, 32'h0);
        cfg_retry_start <= 1'b1;
        cpl_start <= 1'b1;
        for (n = 1; n <= 2100 && t_cpl == 0; n++) begin
            @(posedge mclk);
            cfg_retry_start <= 1'b0;
            cpl_start <= 1'b0;
            #1;
            if (cfg_retry_expired === 1'b1) t_cfg = n;
            if (cpl_timeout === 1'b1) t_cpl = n;
        end
        if (t_cpl == 0) begin
            error_cnt++;
            $display("Error at %0t: timeout got %h expected %h", $time,
                     t_cpl, 32'd2001);
            finish_test;
        end
        chk(t_cfg, 32'd1001);
        chk(t_cpl, 32'd2001);
        // A completion that arrives in time stops the timer
        cpl_start <= 1'b1;
        @(posedge mclk) cpl_start <= 1'b0;
        repeat (10) @(posedge mclk);
        cpl_done <= 1'b1;
        @(posedge mclk) cpl_done <= 1'b0;
        t_cpl = 0;
        for (n = 1; n <= 2100; n++) begin
            @(posedge mclk);
            #1;
            if (cpl_timeout !== 1'b0) t_cpl = n;
        end
        chk(t_cpl, 32'd0);
    endtask : t_timer
    task t_reverse;
        do_reset(1'b0, 1'b1);
        rdx(1'b0, 32'h0920_0000);
        chk(bridge_dir, BCC_REVERSE);
        wr(1'b1, 4'h8, 32'hC900_0000);
        rdx(1'b0, 32'hC920_0000);
        chk(serial_loopback, 1'b1);
        rdx(1'b1, 32'h0);
        chk(i_host.rd_ans, BCC_CFG_RETRY);
        brc_disc_rev <= 1'b1;
        rdx(1'b0, 32'hC920_0000);
        chk(discard_clks, 16'h0400);
    endtask : t_reverse
    ////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        {reset, test_strap_a, reverse_mode_strap} = 3'h4;
        {test_strap_b, test_strap_c, mask_input_strap} = 3'h7;
        {brc_disc_dis, brc_disc_fwd, brc_disc_rev, pci_retry} = 4'h0;
        {pci_retry_done, cfg_retry_start, cpl_start, cpl_done} = 4'h0;
        mem_to_serial = 1'b1;
        error_cnt = 0;
        samples_checked = 0;
        t_forward;
        t_retry;
        t_timer;
        t_reverse;
        finish_test;
    end
endmodule : bcc_chip_ctrl_tb_top

bind bcc_chip_ctrl bcc_chip_ctrl_props i_props (.mclk(mclk), .reset(reset),
    .test_strap_a(test_strap_a), .test_strap_b(test_strap_b),
    .test_strap_c(test_strap_c), .mask_input_strap(mask_input_strap),
    .reverse_mode_strap(reverse_mode_strap), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_from_primary(cfg_from_primary), .cfg_answer(cfg_answer),
    .brc_disc_fwd(brc_disc_fwd), .brc_disc_rev(brc_disc_rev),
    .discard_clks(discard_clks), .serial_loopback(serial_loopback),
    .bridge_dir(bridge_dir));
